// [ieee488_pkg.sv]
package ieee488_pkg;
	// timing
	localparam int CLK_PERIOD_NS = 5;
	localparam int SETTLE_NS = 2000;
	localparam int SETTLE_CYC = (SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int SETTLE_W = 9;
	localparam logic [SETTLE_W-1:0] SETTLE_LOAD = SETTLE_W'(SETTLE_CYC - 1);
	// address setting, decimal 50 selects talk-only
	localparam logic [5:0] TALK_ONLY_ADDR = 6'h32;
	// receive buffer
	localparam int RX_AW = 4;
	localparam int RX_CW = 5;
	localparam logic [RX_CW-1:0] RX_DEPTH = 5'h10;
	// command groups in bits 6:5
	localparam logic [1:0] LAG_GRP = 2'h1;
	localparam logic [1:0] TAG_GRP = 2'h2;
	localparam logic [1:0] SCG_GRP = 2'h3;
	// interface commands, 7 bit
	localparam logic [6:0] CMD_GTL = 7'h01;
	localparam logic [6:0] CMD_SDC = 7'h04;
	localparam logic [6:0] CMD_GET = 7'h08;
	localparam logic [6:0] CMD_LOCKOUT = 7'h11;
	localparam logic [6:0] CMD_DCL = 7'h14;
	localparam logic [6:0] CMD_SPE = 7'h18;
	localparam logic [6:0] CMD_SPD = 7'h19;
	localparam logic [6:0] CMD_UNL = 7'h3f;
	// status byte, bit 6 carries the request
	localparam logic [7:0] STATUS_SRQ_MASK = 8'hbf;
	localparam int RQS_BIT = 6;
	typedef enum logic [3:0] {
		S_IDLE = 4'h1,
		S_SETTLE = 4'h2,
		S_DAV = 4'h4,
		S_DONE = 4'h8
	} src_state_t;
	typedef enum logic [3:0] {
		A_IDLE = 4'h1,
		A_NRDY = 4'h2,
		A_RDY = 4'h4,
		A_ACC = 4'h8
	} acc_state_t;
endpackage

// [rx_byte_mem.sv]
module rx_byte_mem import ieee488_pkg::*; (
	input wire logic clk,
	input wire logic srst,
	input wire logic wrEn,
	input wire logic [RX_AW-1:0] wrAddr,
	input wire logic [7:0] wrData,
	input wire logic rdEn,
	input wire logic [RX_AW-1:0] rdAddr,
	output logic [7:0] rdData_r
);
	logic [7:0] mem [2**RX_AW];

	always_ff @(posedge clk) begin
		if (wrEn) begin
			mem[wrAddr] <= wrData;
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			rdData_r <= 8'h00;
		end else if (rdEn) begin
			rdData_r <= mem[rdAddr];
		end
	end
endmodule

// [ieee488_device_interface.sv]
// Functional notes
// - address setting 50 selects talk-only: send results without any controller.
// - addressable talker puts no data on the bus before its talk address.
// - talk indicator lit while talking or addressed to talk.
// - listen indicator lit while addressed to listen.
// - serial poll returns exactly one status byte; controller polls each requester.
// - no parallel poll response at all.
// - talker with serial poll and talk-only; own listen address untalks it.
// - listener without listen-only; own talk address unlistens it.
// - every transmitted byte goes through the full source handshake.
// - every received byte, command or data, goes through the acceptor handshake.
// - secondary addresses are ignored.
// - service request drives the request line and shows in the status byte.
// - remote/local with local lockout; panel locked from the lockout command until remote enable drops, even while local.
// - universal and selected device clear both honoured.
// - group execute trigger accepted while addressed to listen.
// - never a controller: attention and interface clear are never driven.
// - one output data path for talk-only and addressable operation.
// - only one talker: data lines driven only while addressed to talk or in talk-only, and attention off.
// - device clear flushes input buffer and resets measurement logic.
// - device trigger starts a new measurement.
// - request raised when the OR of mask-enabled status bits other than bit 6 goes from clear to set.
// - local key ignored under lockout; controller must send local.
module ieee488_device_interface import ieee488_pkg::*; (
	input wire logic clk,
	input wire logic srst,
	input wire logic [5:0] addrSetting,
	input wire logic [7:0] dioIn,
	output logic [7:0] dioOut_r,
	output logic dioOe_r,
	input wire logic davIn,
	output logic davOut_r,
	output logic davOe_r,
	input wire logic nrfdIn,
	output logic nrfdOut_r,
	output logic nrfdOe_r,
	input wire logic ndacIn,
	output logic ndacOut_r,
	output logic ndacOe_r,
	input wire logic atnIn,
	input wire logic ifcIn,
	input wire logic renIn,
	output logic srqOut_r,
	output logic srqOe_r,
	input wire logic [7:0] txData,
	input wire logic txValid,
	output logic txReady_r,
	output logic [7:0] rxData,
	output logic rxValid_r,
	input wire logic rxPop,
	input wire logic [7:0] statusIn,
	input wire logic [7:0] srqMask,
	input wire logic localKey,
	output logic talkIndicator_r,
	output logic listenIndicator_r,
	output logic remoteIndicator_r,
	output logic frontPanelLockout_r,
	output logic devClear_r,
	output logic measTrigger_r
);
	function automatic logic isAddr(input logic [6:0] b, input logic [1:0] grp, input logic [4:0] a);
		return (b[6:5] == grp) && (b[4:0] == a);
	endfunction

	logic talk_r, listen_r, remote_r, lockout_r, spMode_r, spSent_r;
	logic srqPend_r, rsvPrev_r, accPulse_r, accCmd_r;
	logic [7:0] accByte_r;
	src_state_t srcState_r;
	acc_state_t accState_r;
	logic [SETTLE_W-1:0] settleCnt_r;
	logic [RX_CW-1:0] rxCount_r;
	logic [RX_AW-1:0] wrPtr_r, rdPtr_r;
	logic [1:0] spBytes_r;
	logic [4:0] busAddr;
	logic [6:0] cmd;
	logic [7:0] statusByte;
	logic talkOnlyMode, tacs, acceptorActive, isCmd, rsv, txTake, spLoad, wrEn, rdEn;

	assign busAddr = addrSetting[4:0];
	assign talkOnlyMode = (addrSetting == TALK_ONLY_ADDR);
	assign tacs = (talk_r || talkOnlyMode) && !atnIn;
	// attention and clear are only sampled here, never driven
	assign acceptorActive = !talkOnlyMode && (atnIn || listen_r);
	assign cmd = accByte_r[6:0];
	assign isCmd = accPulse_r && accCmd_r && !talkOnlyMode;
	assign rsv = |(statusIn & srqMask & STATUS_SRQ_MASK);
	assign statusByte = {statusIn[7], srqPend_r, statusIn[5:0]};
	assign txTake = (srcState_r == S_IDLE) && txValid && txReady_r;
	assign spLoad = (srcState_r == S_IDLE) && !txTake && tacs && spMode_r && !spSent_r;
	assign wrEn = accPulse_r && !accCmd_r && listen_r;
	assign rdEn = (rxCount_r != 5'h00) && (!rxValid_r || rxPop);

	// interface command decode
	always_ff @(posedge clk) begin
		if (srst) begin
			talk_r <= 1'b0;
			listen_r <= 1'b0;
			remote_r <= 1'b0;
			lockout_r <= 1'b0;
			spMode_r <= 1'b0;
			devClear_r <= 1'b0;
			measTrigger_r <= 1'b0;
		end else begin
			devClear_r <= 1'b0;
			measTrigger_r <= 1'b0;
			if (ifcIn) begin
				talk_r <= 1'b0;
				listen_r <= 1'b0;
				spMode_r <= 1'b0;
			end else if (isCmd) begin
				if (isAddr(cmd, LAG_GRP, busAddr)) begin
					listen_r <= 1'b1;
					talk_r <= 1'b0;
					remote_r <= renIn;
				end else if (isAddr(cmd, TAG_GRP, busAddr)) begin
					talk_r <= 1'b1;
					listen_r <= 1'b0;
				end else if (cmd[6:5] == TAG_GRP) begin
					talk_r <= 1'b0;
				end else if (cmd == CMD_UNL) begin
					listen_r <= 1'b0;
				end else if (cmd == CMD_SPE) begin
					spMode_r <= 1'b1;
				end else if (cmd == CMD_SPD) begin
					spMode_r <= 1'b0;
				end else if (cmd == CMD_LOCKOUT) begin
					lockout_r <= 1'b1;
				end else if (cmd == CMD_DCL || (cmd == CMD_SDC && listen_r)) begin
					devClear_r <= 1'b1;
				end else if (cmd == CMD_GET && listen_r) begin
					measTrigger_r <= 1'b1;
				end else if (cmd == CMD_GTL && listen_r) begin
					remote_r <= 1'b0;
				end
			end
			if (!renIn) begin
				remote_r <= 1'b0;
				lockout_r <= 1'b0;
			end else if (localKey && !lockout_r) begin
				remote_r <= 1'b0;
			end
		end
	end

	// indicators
	always_ff @(posedge clk) begin
		if (srst) begin
			talkIndicator_r <= 1'b0;
			listenIndicator_r <= 1'b0;
			remoteIndicator_r <= 1'b0;
			frontPanelLockout_r <= 1'b0;
		end else begin
			talkIndicator_r <= talk_r || talkOnlyMode;
			listenIndicator_r <= listen_r && !talkOnlyMode;
			remoteIndicator_r <= remote_r;
			frontPanelLockout_r <= lockout_r;
		end
	end

	// acceptor handshake
	always_ff @(posedge clk) begin
		if (srst) begin
			accState_r <= A_IDLE;
			nrfdOe_r <= 1'b0;
			ndacOe_r <= 1'b0;
			accPulse_r <= 1'b0;
			accCmd_r <= 1'b0;
			accByte_r <= 8'h00;
		end else begin
			accPulse_r <= 1'b0;
			case (accState_r)
				A_IDLE: begin
					if (acceptorActive) begin
						accState_r <= A_NRDY;
						nrfdOe_r <= 1'b1;
						ndacOe_r <= 1'b1;
					end
				end
				A_NRDY: begin
					if (!acceptorActive) begin
						accState_r <= A_IDLE;
						nrfdOe_r <= 1'b0;
						ndacOe_r <= 1'b0;
					end else if (!davIn && (atnIn || rxCount_r < RX_DEPTH)) begin
						accState_r <= A_RDY;
						nrfdOe_r <= 1'b0;
					end
				end
				A_RDY: begin
					if (!acceptorActive) begin
						accState_r <= A_IDLE;
						ndacOe_r <= 1'b0;
					end else if (davIn) begin
						accState_r <= A_ACC;
						accByte_r <= dioIn;
						accCmd_r <= atnIn;
						accPulse_r <= 1'b1;
						nrfdOe_r <= 1'b1;
						ndacOe_r <= 1'b0;
					end
				end
				A_ACC: begin
					if (!acceptorActive) begin
						accState_r <= A_IDLE;
						nrfdOe_r <= 1'b0;
					end else if (!davIn) begin
						accState_r <= A_NRDY;
						ndacOe_r <= 1'b1;
					end
				end
				default: begin
					accState_r <= A_IDLE;
					nrfdOe_r <= 1'b0;
					ndacOe_r <= 1'b0;
				end
			endcase
		end
	end

	// source handshake
	always_ff @(posedge clk) begin
		if (srst) begin
			srcState_r <= S_IDLE;
			davOe_r <= 1'b0;
			dioOe_r <= 1'b0;
			dioOut_r <= 8'h00;
			settleCnt_r <= '0;
			spSent_r <= 1'b0;
			txReady_r <= 1'b0;
		end else begin
			txReady_r <= 1'b0;
			if (atnIn) begin
				spSent_r <= 1'b0;
			end
			if (devClear_r) begin
				srcState_r <= S_IDLE;
				davOe_r <= 1'b0;
				dioOe_r <= 1'b0;
			end else begin
				case (srcState_r)
					S_IDLE: begin
						dioOe_r <= 1'b0;
						davOe_r <= 1'b0;
						if (txTake) begin
							dioOut_r <= txData;
							settleCnt_r <= SETTLE_LOAD;
							srcState_r <= S_SETTLE;
						end else if (spLoad) begin
							dioOut_r <= statusByte;
							spSent_r <= 1'b1;
							settleCnt_r <= SETTLE_LOAD;
							srcState_r <= S_SETTLE;
						end else begin
							txReady_r <= tacs && !spMode_r;
						end
					end
					S_SETTLE: begin
						dioOe_r <= tacs;
						if (!tacs) begin
							settleCnt_r <= SETTLE_LOAD;
						end else if (settleCnt_r != '0) begin
							settleCnt_r <= settleCnt_r - 1'b1;
						end else if (!nrfdIn && dioOe_r) begin
							davOe_r <= 1'b1;
							srcState_r <= S_DAV;
						end
					end
					S_DAV: begin
						if (!tacs) begin
							davOe_r <= 1'b0;
							dioOe_r <= 1'b0;
							settleCnt_r <= SETTLE_LOAD;
							srcState_r <= S_SETTLE;
						end else if (!ndacIn) begin
							davOe_r <= 1'b0;
							srcState_r <= S_DONE;
						end
					end
					S_DONE: begin
						dioOe_r <= 1'b0;
						srcState_r <= S_IDLE;
					end
					default: begin
						davOe_r <= 1'b0;
						dioOe_r <= 1'b0;
						srcState_r <= S_IDLE;
					end
				endcase
			end
		end
	end

	// service request, set wins over clear
	always_ff @(posedge clk) begin
		if (srst) begin
			srqPend_r <= 1'b0;
			rsvPrev_r <= 1'b0;
			srqOe_r <= 1'b0;
		end else begin
			rsvPrev_r <= rsv;
			if (rsv && !rsvPrev_r) begin
				srqPend_r <= 1'b1;
			end else if (spLoad) begin
				srqPend_r <= 1'b0;
			end
			srqOe_r <= srqPend_r;
		end
	end

	// driven level of each open line while enabled
	always_ff @(posedge clk) begin
		if (srst) begin
			davOut_r <= 1'b0;
			nrfdOut_r <= 1'b0;
			ndacOut_r <= 1'b0;
			srqOut_r <= 1'b0;
		end else begin
			davOut_r <= 1'b1;
			nrfdOut_r <= 1'b1;
			ndacOut_r <= 1'b1;
			srqOut_r <= 1'b1;
		end
	end

	// input buffer pointers
	always_ff @(posedge clk) begin
		if (srst || devClear_r) begin
			wrPtr_r <= '0;
			rdPtr_r <= '0;
			rxCount_r <= '0;
			rxValid_r <= 1'b0;
		end else begin
			wrPtr_r <= wrPtr_r + RX_AW'(wrEn);
			rdPtr_r <= rdPtr_r + RX_AW'(rdEn);
			rxCount_r <= rxCount_r + RX_CW'(wrEn) - RX_CW'(rdEn);
			if (rdEn) begin
				rxValid_r <= 1'b1;
			end else if (rxPop) begin
				rxValid_r <= 1'b0;
			end
		end
	end

	rx_byte_mem u_mem (
		.clk(clk),
		.srst(srst),
		.wrEn(wrEn),
		.wrAddr(wrPtr_r),
		.wrData(accByte_r),
		.rdEn(rdEn),
		.rdAddr(rdPtr_r),
		.rdData_r(rxData)
	);

	// serial poll byte count per poll session
	always_ff @(posedge clk) begin
		if (srst || atnIn) begin
			spBytes_r <= 2'h0;
		end else if (spLoad && spBytes_r != 2'h3) begin
			spBytes_r <= spBytes_r + 2'h1;
		end
	end

	sequence s_cmd(logic [6:0] c);
		accPulse_r && accCmd_r && !ifcIn && !talkOnlyMode && cmd == c;
	endsequence

	property p_mta;
		@(posedge clk) disable iff (srst)
		s_cmd({TAG_GRP, busAddr}) |-> ##2 talkIndicator_r && !listenIndicator_r;
	endproperty
	a_mta: assert property (p_mta) else $error("talk address did not set talk state");

	property p_mla;
		@(posedge clk) disable iff (srst)
		s_cmd({LAG_GRP, busAddr}) |-> ##2 listenIndicator_r && !talkIndicator_r;
	endproperty
	a_mla: assert property (p_mla) else $error("listen address did not set listen state");

	property p_secondary;
		@(posedge clk) disable iff (srst)
		isCmd && !ifcIn && cmd[6:5] == SCG_GRP |=> $stable(talk_r) && $stable(listen_r);
	endproperty
	a_secondary: assert property (p_secondary) else $error("secondary address changed state");

	property p_get;
		@(posedge clk) disable iff (srst)
		s_cmd(CMD_GET) and listen_r |=> measTrigger_r;
	endproperty
	a_get: assert property (p_get) else $error("trigger not issued");

	property p_dcl;
		@(posedge clk) disable iff (srst)
		s_cmd(CMD_DCL) |=> devClear_r ##1 !rxValid_r && rxCount_r == 5'h00;
	endproperty
	a_dcl: assert property (p_dcl) else $error("device clear not honoured");

	property p_lockout;
		@(posedge clk) disable iff (srst)
		lockout_r && renIn && localKey && remote_r && !accPulse_r |=> remote_r;
	endproperty
	a_lockout: assert property (p_lockout) else $error("local key released lockout");

	property p_dio_gate;
		@(posedge clk) disable iff (srst)
		dioOe_r |-> $past(tacs);
	endproperty
	a_dio_gate: assert property (p_dio_gate) else $error("data driven while not talker");

	property p_atn_quiet;
		@(posedge clk) disable iff (srst)
		atnIn && $past(atnIn) |-> !dioOe_r && !davOe_r;
	endproperty
	a_atn_quiet: assert property (p_atn_quiet) else $error("data driven under attention");

	property p_dav_ready;
		@(posedge clk) disable iff (srst)
		$rose(davOe_r) |-> !$past(nrfdIn) && $past(settleCnt_r) == '0 && dioOe_r;
	endproperty
	a_dav_ready: assert property (p_dav_ready) else $error("valid asserted before ready");

	property p_acc_release;
		@(posedge clk) disable iff (srst)
		$fell(ndacOe_r) && accState_r == A_ACC |-> accPulse_r && nrfdOe_r;
	endproperty
	a_acc_release: assert property (p_acc_release) else $error("accepted without latching");

	property p_sp_once;
		@(posedge clk) disable iff (srst)
		spBytes_r <= 2'h1;
	endproperty
	a_sp_once: assert property (p_sp_once) else $error("more than one status byte");

	property p_srq;
		@(posedge clk) disable iff (srst)
		$rose(rsv) |-> ##2 srqOe_r;
	endproperty
	a_srq: assert property (p_srq) else $error("request line not raised");

	property p_talk_only;
		@(posedge clk) disable iff (srst)
		talkOnlyMode && $past(talkOnlyMode) && !$past(srst) |-> talkIndicator_r && !listenIndicator_r;
	endproperty
	a_talk_only: assert property (p_talk_only) else $error("talk-only state wrong");
endmodule

// [bus_ctrl_model.sv]
module bus_ctrl_model (
	input wire logic clk,
	input wire logic [7:0] dioW,
	input wire logic davW,
	input wire logic nrfdW,
	input wire logic ndacW,
	output logic [7:0] pDio,
	output logic pDav,
	output logic pNrfd,
	output logic pNdac,
	output logic atn,
	output logic ifc,
	output logic ren
);
	timeunit 1ns;
	timeprecision 1ps;
	int timeouts = 0;
	initial begin
		pDio = 8'hff;
		pDav = 1'b0;
		pNrfd = 1'b0;
		pNdac = 1'b0;
		atn = 1'b0;
		ifc = 1'b0;
		ren = 1'b0;
	end
	task automatic set_lines(input logic a, input logic r, input logic i);
		@(negedge clk);
		atn = a;
		ren = r;
		ifc = i;
	endtask
	// controller as source, one byte
	task automatic send_byte(input logic a, input logic [7:0] b);
		int n;
		@(negedge clk);
		atn = a;
		pDio = b;
		@(negedge clk);
		for (n = 0; n < 200 && nrfdW; n++) @(negedge clk);
		if (n == 200) timeouts++;
		pDav = 1'b1;
		@(negedge clk);
		for (n = 0; n < 200 && ndacW; n++) @(negedge clk);
		if (n == 200) timeouts++;
		pDav = 1'b0;
		// released lines show the inverse
		pDio = ~b;
	endtask
	// controller or printer as acceptor, optionally slow
	task automatic recv_byte(output logic [7:0] b, input int slow);
		int n;
		@(negedge clk);
		pNdac = 1'b1;
		pNrfd = 1'b0;
		for (n = 0; n < 1000 && !davW; n++) @(negedge clk);
		if (n == 1000) timeouts++;
		b = dioW;
		pNrfd = 1'b1;
		repeat (slow) @(negedge clk);
		pNdac = 1'b0;
		for (n = 0; n < 200 && davW; n++) @(negedge clk);
		if (n == 200) timeouts++;
		pNdac = 1'b1;
		@(negedge clk);
		pNrfd = 1'b0;
		pNdac = 1'b0;
	endtask
endmodule

// [tb.sv]
`define CHK(a, e) check(64'(a), 64'(e))
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	import ieee488_pkg::*;
	logic clk, srst, txValid, rxPop, localKey, davPrev;
	logic [5:0] addrSetting;
	logic [7:0] txData, statusIn, srqMask, rxData, dioOut_r, pDio, dioW, b0, b1;
	logic dioOe_r, davOut_r, davOe_r, nrfdOut_r, nrfdOe_r, ndacOut_r, ndacOe_r, srqOut_r, srqOe_r;
	logic txReady_r, rxValid_r, talkIndicator_r, listenIndicator_r, remoteIndicator_r;
	logic frontPanelLockout_r, devClear_r, measTrigger_r;
	logic pDav, pNrfd, pNdac, atn, ifc, ren, davW, nrfdW, ndacW;
	int mismatches = 0, total_checks = 0, clrCount = 0, trigCount = 0, davRise = 0, d0, c0, t0;
	// wired-or of asserted lines
	assign davW = (davOe_r & davOut_r) | pDav;
	assign nrfdW = (nrfdOe_r & nrfdOut_r) | pNrfd;
	assign ndacW = (ndacOe_r & ndacOut_r) | pNdac;
	assign dioW = dioOe_r ? dioOut_r : pDio;
	ieee488_device_interface ieee488_device_interface_inst (.clk(clk), .srst(srst), .addrSetting(addrSetting),
		.dioIn(dioW), .dioOut_r(dioOut_r), .dioOe_r(dioOe_r), .davIn(davW), .davOut_r(davOut_r),
		.davOe_r(davOe_r), .nrfdIn(nrfdW), .nrfdOut_r(nrfdOut_r), .nrfdOe_r(nrfdOe_r), .ndacIn(ndacW),
		.ndacOut_r(ndacOut_r), .ndacOe_r(ndacOe_r), .atnIn(atn), .ifcIn(ifc), .renIn(ren),
		.srqOut_r(srqOut_r), .srqOe_r(srqOe_r), .txData(txData), .txValid(txValid), .txReady_r(txReady_r),
		.rxData(rxData), .rxValid_r(rxValid_r), .rxPop(rxPop), .statusIn(statusIn), .srqMask(srqMask),
		.localKey(localKey), .talkIndicator_r(talkIndicator_r), .listenIndicator_r(listenIndicator_r),
		.remoteIndicator_r(remoteIndicator_r), .frontPanelLockout_r(frontPanelLockout_r),
		.devClear_r(devClear_r), .measTrigger_r(measTrigger_r));
	bus_ctrl_model bus_ctrl_model_inst (.clk(clk), .dioW(dioW), .davW(davW), .nrfdW(nrfdW), .ndacW(ndacW),
		.pDio(pDio), .pDav(pDav), .pNrfd(pNrfd), .pNdac(pNdac), .atn(atn), .ifc(ifc), .ren(ren));
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	// counts pulses and transmitted bytes
	always @(posedge clk) begin
		davPrev <= davOe_r;
		if (davOe_r === 1'b1 && davPrev !== 1'b1) davRise++;
		if (devClear_r === 1'b1) clrCount++;
		if (measTrigger_r === 1'b1) trigCount++;
	end
	task automatic check(input logic [63:0] a, input logic [63:0] e);
		total_checks++;
		if (a !== e) begin
			mismatches++;
			$display("mismatch at %0t: got %h expected %h", $time, a, e);
		end
	endtask
	task automatic cycles(input int n);
		repeat (n) @(negedge clk);
	endtask
	task automatic cmd(input logic [7:0] b);
		bus_ctrl_model_inst.send_byte(1'b1, b);
	endtask
	task automatic offer_tx(input logic [7:0] b);
		int n;
		@(negedge clk);
		txData = b;
		txValid = 1'b1;
		for (n = 0; n < 2000 && txReady_r !== 1'b1; n++) @(negedge clk);
		if (n == 2000) mismatches++;
		@(negedge clk);
		txValid = 1'b0;
	endtask
	task automatic test_reset();
		`CHK(talkIndicator_r, 0);
		`CHK(listenIndicator_r, 0);
		`CHK({dioOe_r, davOe_r, srqOe_r}, 0);
	endtask
	task automatic test_listen_talk();
		d0 = davRise;
		txData = 8'h5a;
		txValid = 1'b1;
		cmd(8'h23);
		bus_ctrl_model_inst.send_byte(1'b0, 8'h37);
		cycles(6);
		`CHK(listenIndicator_r, 1);
		`CHK({rxValid_r, rxData}, 9'h137);
		rxPop = 1'b1;
		cycles(1);
		rxPop = 1'b0;
		cmd(8'h43);
		cycles(5);
		`CHK(talkIndicator_r, 1);
		`CHK(listenIndicator_r, 0);
		`CHK(davRise, d0);
		txValid = 1'b0;
		bus_ctrl_model_inst.set_lines(1'b0, 1'b0, 1'b0);
		fork
			begin
				offer_tx(8'h5a);
				offer_tx(8'ha5);
			end
			begin
				bus_ctrl_model_inst.recv_byte(b0, 0);
				bus_ctrl_model_inst.recv_byte(b1, 20);
			end
		join
		`CHK({b0, b1}, 16'h5aa5);
		`CHK(davRise, d0 + 2);
		cmd(8'h23);
		cycles(5);
		`CHK({talkIndicator_r, listenIndicator_r}, 2'h1);
		cmd(8'h3f);
	endtask
	task automatic test_poll();
		statusIn = 8'h01;
		srqMask = 8'h01;
		cycles(4);
		`CHK({srqOe_r, srqOut_r}, 2'h3);
		d0 = davRise;
		cmd(8'h18);
		cmd(8'h43);
		bus_ctrl_model_inst.set_lines(1'b0, 1'b0, 1'b0);
		bus_ctrl_model_inst.recv_byte(b0, 5);
		`CHK(b0, 8'h41);
		cycles(450);
		`CHK(davRise, d0 + 1);
		`CHK(srqOe_r, 0);
		cmd(8'h19);
		cmd(8'h5f);
		cycles(5);
		`CHK(talkIndicator_r, 0);
		srqMask = 8'h00;
	endtask
	task automatic test_clear_trigger();
		c0 = clrCount;
		t0 = trigCount;
		cmd(8'h23);
		cmd(8'h08);
		cmd(8'h04);
		cycles(4);
		`CHK(trigCount, t0 + 1);
		`CHK(clrCount, c0 + 1);
		cmd(8'h63);
		cycles(5);
		`CHK(listenIndicator_r, 1);
		cmd(8'h3f);
		cmd(8'h08);
		cmd(8'h14);
		cycles(4);
		`CHK(trigCount, t0 + 1);
		`CHK(clrCount, c0 + 2);
		cmd(8'h23);
		bus_ctrl_model_inst.set_lines(1'b1, 1'b0, 1'b1);
		bus_ctrl_model_inst.set_lines(1'b1, 1'b0, 1'b0);
		cycles(5);
		`CHK(listenIndicator_r, 0);
	endtask
	task automatic test_lockout();
		bus_ctrl_model_inst.set_lines(1'b1, 1'b1, 1'b0);
		cmd(8'h23);
		cycles(5);
		`CHK(remoteIndicator_r, 1);
		localKey = 1'b1;
		cycles(3);
		localKey = 1'b0;
		cycles(3);
		`CHK(remoteIndicator_r, 0);
		cmd(8'h23);
		cmd(8'h11);
		cycles(5);
		`CHK({remoteIndicator_r, frontPanelLockout_r}, 2'h3);
		localKey = 1'b1;
		cycles(3);
		localKey = 1'b0;
		cycles(3);
		`CHK({remoteIndicator_r, frontPanelLockout_r}, 2'h3);
		cmd(8'h01);
		cycles(5);
		`CHK({remoteIndicator_r, frontPanelLockout_r}, 2'h1);
		bus_ctrl_model_inst.set_lines(1'b1, 1'b0, 1'b0);
		cycles(5);
		`CHK(frontPanelLockout_r, 0);
		cmd(8'h3f);
	endtask
	task automatic test_talk_only();
		addrSetting = 6'h32;
		srst = 1'b1;
		cycles(16);
		srst = 1'b0;
		bus_ctrl_model_inst.set_lines(1'b0, 1'b0, 1'b0);
		fork
			offer_tx(8'hc3);
			bus_ctrl_model_inst.recv_byte(b0, 3);
		join
		`CHK(b0, 8'hc3);
		`CHK({talkIndicator_r, listenIndicator_r}, 2'h2);
	endtask
	task automatic test_done();
		$display("checks %0d mismatches %0d", total_checks, mismatches);
		if (mismatches == 0 && total_checks > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	initial begin
		srst = 1'b1;
		addrSetting = 6'h03;
		txData = 8'h00;
		txValid = 1'b0;
		rxPop = 1'b0;
		statusIn = 8'h00;
		srqMask = 8'h00;
		localKey = 1'b0;
		cycles(16);
		srst = 1'b0;
		test_reset();
		test_listen_talk();
		test_poll();
		test_clear_trigger();
		test_lockout();
		test_talk_only();
		`CHK(bus_ctrl_model_inst.timeouts, 0);
		test_done();
	end
	initial begin
		#200000;
		mismatches++;
		test_done();
	end
endmodule
